// ### hw/ivm_regs.svh
`ifndef IVM_REGS_SVH
`define IVM_REGS_SVH

// ============================================================
// vector table geometry
`define IVM_ADDR_W 16
`define IVM_NUM_W 5
`define IVM_VEC_STEP 16'h0002
`define IVM_VEC_BASE 16'h0000

// ============================================================
// vector numbers (1-based)
`define IVM_VEC_RESET 5'h01
`define IVM_VEC_SUSP 5'h02
`define IVM_VEC_USB 5'h03
`define IVM_VEC_EXT0 5'h04
`define IVM_VEC_TIMB_OVF 5'h08
`define IVM_VEC_WT_CAPT 5'h09
`define IVM_VEC_WT_MA 5'h0A
`define IVM_VEC_WT_MB 5'h0B
`define IVM_VEC_WT_OVF 5'h0C
`define IVM_VEC_TIMA_OVF 5'h0D
`define IVM_VEC_SPI 5'h0E
`define IVM_VEC_UART0 5'h0F
`define IVM_VEC_UART1 5'h10

// ============================================================
// source bit positions in the request vector (vector number - 2)
`define IVM_SRC_NUM 15

`endif

// ### hw/ivm_pkg.sv
package ivm_pkg;
    typedef logic [15:0] ivm_addr_t;
    typedef logic [4:0] ivm_num_t;
    typedef logic [14:0] ivm_src_t;
    typedef enum logic [1:0] {
        IVM_RESET_HOLD,
        IVM_RUN
    } ivm_state_t;
endpackage

// ### hw/ivm_pick_if.sv
interface ivm_pick_if;
    logic [14:0] pending;
    logic found;
    logic [4:0] vec_num;
    logic [15:0] vec_addr;
    modport owner (output pending, input found, input vec_num, input vec_addr);
    modport picker (input pending, output found, output vec_num, output vec_addr);
endinterface

// ### hw/ivm_picker.sv
`include "ivm_regs.svh"

module ivm_picker (
    ivm_pick_if.picker pk
);
    // ============================================================
    // number to address
    function automatic ivm_pkg::ivm_addr_t ivm_num_to_addr(input ivm_pkg::ivm_num_t n);
        logic [15:0] idx;
        idx = {11'h000, n} - 16'h0001;
        ivm_num_to_addr = `IVM_VEC_BASE + 16'(idx * `IVM_VEC_STEP);
    endfunction

    // ============================================================
    // lowest vector number wins
    always_comb begin
        pk.found = 1'b0;
        pk.vec_num = `IVM_VEC_RESET;
        for (int i = `IVM_SRC_NUM - 1; i >= 0; i--) begin
            if (pk.pending[i]) begin
                pk.found = 1'b1;
                pk.vec_num = 5'(i + 2);
            end
        end
        pk.vec_addr = ivm_num_to_addr(pk.vec_num);
    end
endmodule // ivm_picker

// ### hw/ivm_mapper.sv
`include "ivm_regs.svh"

// Operation
// - a pin or watchdog reset sends execution to address 0000h, vector 1.
// - usb suspend or resume uses vector 2 at address 0002h.
// - usb hardware and usb dma requests share vector 3 at address 0004h.
// - external requests 0 to 3 use vectors 4 to 7 at 0006h to 000Ch.
// - wide timer capture, match a and match b use 0010h, 0012h and 0014h.
// - timer b overflow uses 000Eh, wide timer 0016h and timer a 0018h.
// - serial port transfer completion uses vector 14 at 001Ah.
// - first uart uses 001Ch and second uart uses 001Eh.
// - vector addresses step by two sixteen-bit words per vector number.
module ivm_mapper (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic reset_pin_b_i,
    input wire logic watchdog_reset_i,
    input wire logic usb_suspend_resume_irq_i,
    input wire logic usb_hw_irq_i,
    input wire logic usb_dma_irq_i,
    input wire logic ext_request_0_i,
    input wire logic ext_request_1_i,
    input wire logic ext_request_2_i,
    input wire logic ext_request_3_i,
    input wire logic timer_b_overflow_irq_i,
    input wire logic wide_timer_capture_irq_i,
    input wire logic wide_timer_match_a_irq_i,
    input wire logic wide_timer_match_b_irq_i,
    input wire logic wide_timer_overflow_irq_i,
    input wire logic timer_a_overflow_irq_i,
    input wire logic serial_port_done_irq_i,
    input wire logic first_uart_irq_i,
    input wire logic second_uart_irq_i,
    input wire logic irq_accept_i,
    output logic core_reset_o,
    output logic irq_pending_o,
    output logic [15:0] vec_addr_o,
    output logic [4:0] vec_num_o,
    output logic pc_load_o
);
    // ============================================================
    // state
    typedef struct packed {
        ivm_pkg::ivm_state_t state;
        logic [1:0] pin_sync;
        logic [1:0] ext_sync0;
        logic [1:0] ext_sync1;
        logic [1:0] ext_sync2;
        logic [1:0] ext_sync3;
        logic core_reset;
        logic pending;
        logic [15:0] vec_addr;
        logic [4:0] vec_num;
        logic pc_load;
    } ivm_regs_t;

    ivm_regs_t st_reg;
    ivm_regs_t st_next;
    ivm_pkg::ivm_src_t src;
    ivm_pick_if pick ();

    ivm_picker u_picker (
        .pk(pick.picker)
    );

    // external pins pass two flops; peripheral requests are same-clock
    always_comb begin
        src = '0;
        src[0] = usb_suspend_resume_irq_i;
        src[1] = usb_hw_irq_i | usb_dma_irq_i;
        src[2] = st_reg.ext_sync0[1];
        src[3] = st_reg.ext_sync1[1];
        src[4] = st_reg.ext_sync2[1];
        src[5] = st_reg.ext_sync3[1];
        src[6] = timer_b_overflow_irq_i;
        src[7] = wide_timer_capture_irq_i;
        src[8] = wide_timer_match_a_irq_i;
        src[9] = wide_timer_match_b_irq_i;
        src[10] = wide_timer_overflow_irq_i;
        src[11] = timer_a_overflow_irq_i;
        src[12] = serial_port_done_irq_i;
        src[13] = first_uart_irq_i;
        src[14] = second_uart_irq_i;
    end

    assign pick.pending = src;

    // ============================================================
    // next state
    always_comb begin
        logic rst_req;
        rst_req = 1'b0;
        st_next = st_reg;
        st_next.pin_sync = {st_reg.pin_sync[0], ~reset_pin_b_i};
        st_next.ext_sync0 = {st_reg.ext_sync0[0], ext_request_0_i};
        st_next.ext_sync1 = {st_reg.ext_sync1[0], ext_request_1_i};
        st_next.ext_sync2 = {st_reg.ext_sync2[0], ext_request_2_i};
        st_next.ext_sync3 = {st_reg.ext_sync3[0], ext_request_3_i};
        rst_req = st_reg.pin_sync[1] | watchdog_reset_i;
        st_next.pc_load = 1'b0;
        unique case (st_reg.state)
            ivm_pkg::IVM_RESET_HOLD: begin
                // release loads the reset vector once
                st_next.core_reset = rst_req;
                st_next.pending = 1'b0;
                st_next.vec_num = `IVM_VEC_RESET;
                st_next.vec_addr = `IVM_VEC_BASE;
                if (!rst_req) begin
                    st_next.pc_load = 1'b1;
                    st_next.state = ivm_pkg::IVM_RUN;
                end
            end
            ivm_pkg::IVM_RUN: begin
                if (rst_req) begin
                    st_next.core_reset = 1'b1;
                    st_next.pending = 1'b0;
                    st_next.vec_num = `IVM_VEC_RESET;
                    st_next.vec_addr = `IVM_VEC_BASE;
                    st_next.state = ivm_pkg::IVM_RESET_HOLD;
                end else begin
                    // choice frozen on accept, so the load carries the vector the core saw
                    st_next.pending = pick.found;
                    if (pick.found && !(irq_accept_i && st_reg.pending)) begin
                        st_next.vec_num = pick.vec_num;
                        st_next.vec_addr = pick.vec_addr;
                    end
                    st_next.pc_load = irq_accept_i & st_reg.pending;
                end
            end
            default: begin
                st_next.state = ivm_pkg::IVM_RESET_HOLD;
                st_next.core_reset = 1'b1;
                st_next.pending = 1'b0;
                st_next.vec_num = `IVM_VEC_RESET;
                st_next.vec_addr = `IVM_VEC_BASE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
            st_reg.state <= ivm_pkg::IVM_RESET_HOLD;
            st_reg.core_reset <= 1'b1;
            st_reg.vec_num <= `IVM_VEC_RESET;
            st_reg.vec_addr <= `IVM_VEC_BASE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign core_reset_o = st_reg.core_reset;
    assign irq_pending_o = st_reg.pending;
    assign vec_addr_o = st_reg.vec_addr;
    assign vec_num_o = st_reg.vec_num;
    assign pc_load_o = st_reg.pc_load;

    // ============================================================
    // checks
    // state passed as an argument so the property sees its sampled value
    function automatic logic state_run(input ivm_pkg::ivm_state_t s);
        state_run = s == ivm_pkg::IVM_RUN;
    endfunction

    // addresses spelled out here, not taken from the picker's function
    a_reset_vector_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        core_reset_o |-> vec_addr_o == 16'h0000 && vec_num_o == 5'h01)
        else $error("reset vector not at zero");
    a_watchdog_resets: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        watchdog_reset_i |=> core_reset_o)
        else $error("watchdog did not reset core");
    a_pin_resets: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        st_reg.pin_sync[1] |=> core_reset_o)
        else $error("reset pin did not reset core");
    a_suspend_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_pending_o && vec_num_o == 5'h02 |-> vec_addr_o == 16'h0002)
        else $error("suspend vector address wrong");
    a_usb_shared: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (state_run(st_reg.state) && !usb_suspend_resume_irq_i && (usb_hw_irq_i || usb_dma_irq_i)
         && !watchdog_reset_i && !st_reg.pin_sync[1] && !(irq_accept_i && irq_pending_o))
        |=> vec_addr_o == 16'h0004)
        else $error("usb vector not 0004h");
    a_ext_zero_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_pending_o && vec_num_o == 5'h04 |-> vec_addr_o == 16'h0006)
        else $error("external request 0 vector wrong");
    a_ext_vectors: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_pending_o && vec_num_o == 5'h07 |-> vec_addr_o == 16'h000C)
        else $error("external request 3 vector wrong");
    a_capture_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_pending_o && vec_num_o == 5'h09 |-> vec_addr_o == 16'h0010)
        else $error("capture vector wrong");
    a_timer_vectors: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_pending_o && vec_num_o == 5'h0B |-> vec_addr_o == 16'h0014)
        else $error("match b vector wrong");
    a_timer_b_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_pending_o && vec_num_o == 5'h08 |-> vec_addr_o == 16'h000E)
        else $error("timer b overflow vector wrong");
    a_overflow_vectors: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_pending_o && vec_num_o == 5'h0D |-> vec_addr_o == 16'h0018)
        else $error("timer a overflow vector wrong");
    a_serial_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_pending_o && vec_num_o == 5'h0E |-> vec_addr_o == 16'h001A)
        else $error("serial port vector wrong");
    a_first_uart_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_pending_o && vec_num_o == 5'h0F |-> vec_addr_o == 16'h001C)
        else $error("first uart vector wrong");
    a_uart_vectors: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_pending_o && vec_num_o == 5'h10 |-> vec_addr_o == 16'h001E)
        else $error("second uart vector wrong");
    a_step_by_two: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        vec_addr_o == {10'h000, vec_num_o - 5'h01, 1'b0})
        else $error("vector address step not two");
    a_reset_no_pending: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        core_reset_o |-> !irq_pending_o)
        else $error("request pending during reset");
    a_lowest_first: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (state_run(st_reg.state) && usb_suspend_resume_irq_i && !watchdog_reset_i
         && !st_reg.pin_sync[1] && !(irq_accept_i && irq_pending_o)) |=> vec_num_o == 5'h02)
        else $error("lower vector not taken first");
    a_load_on_accept: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        pc_load_o && !$past(core_reset_o) |-> $past(irq_accept_i) && $past(irq_pending_o)
        && $stable(vec_addr_o))
        else $error("load not tied to accept");
    a_vector_frozen: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_accept_i && irq_pending_o && !watchdog_reset_i && !st_reg.pin_sync[1]
        |=> pc_load_o && $stable(vec_addr_o))
        else $error("accepted vector not loaded unchanged");
endmodule // ivm_mapper

// ### tb/ivm_core_model.sv
// ============================================================
// core side: takes a pending request once, after a set wait
module ivm_core_model (
    input wire logic clk_i,
    input wire logic core_reset_i,
    input wire logic irq_pending_i,
    input wire logic [3:0] delay_i,
    input wire logic rogue_i,
    output logic irq_accept_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic served = 1'b0;
    logic [3:0] wait_cnt = 4'h0;
    initial irq_accept_o = 1'b0;
    // served stands in for the handler clearing its source
    always @(negedge clk_i) begin
        if (rogue_i) begin
            irq_accept_o <= 1'b1;
        end else if (irq_pending_i === 1'b1 && core_reset_i !== 1'b1 && !served) begin
            irq_accept_o <= (wait_cnt >= delay_i);
            served <= (wait_cnt >= delay_i);
            wait_cnt <= wait_cnt + 4'h1;
        end else begin
            irq_accept_o <= 1'b0;
            if (irq_pending_i !== 1'b1) begin
                served <= 1'b0;
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule // ivm_core_model

// ### tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0, pin_b = 1'b1, wdog = 1'b0, rogue = 1'b0;
    logic [15:0] src = 16'h0000;
    logic [3:0] delay = 4'h0;
    logic accept, core_reset, pending, pc_load;
    logic [15:0] vec_addr, e;
    logic [4:0] vec_num;
    logic [15:0] exp_q[$];
    int fails = 0, n_tests = 0, seed = 83;
    always #2.5 sys_clk = ~sys_clk;

    ivm_mapper dut_u (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .reset_pin_b_i(pin_b),
        .watchdog_reset_i(wdog), .usb_suspend_resume_irq_i(src[0]),
        .usb_hw_irq_i(src[1]), .usb_dma_irq_i(src[2]), .ext_request_0_i(src[3]),
        .ext_request_1_i(src[4]), .ext_request_2_i(src[5]), .ext_request_3_i(src[6]),
        .timer_b_overflow_irq_i(src[7]), .wide_timer_capture_irq_i(src[8]),
        .wide_timer_match_a_irq_i(src[9]), .wide_timer_match_b_irq_i(src[10]),
        .wide_timer_overflow_irq_i(src[11]), .timer_a_overflow_irq_i(src[12]),
        .serial_port_done_irq_i(src[13]), .first_uart_irq_i(src[14]),
        .second_uart_irq_i(src[15]), .irq_accept_i(accept), .core_reset_o(core_reset),
        .irq_pending_o(pending), .vec_addr_o(vec_addr), .vec_num_o(vec_num),
        .pc_load_o(pc_load));

    ivm_core_model core_u (.clk_i(sys_clk), .core_reset_i(core_reset),
        .irq_pending_i(pending), .delay_i(delay), .rogue_i(rogue), .irq_accept_o(accept));

    // lowest set source wins; bits 1 and 2 share one vector
    function automatic logic [15:0] exp_addr(input logic [15:0] m);
        logic [15:0] a;
        a = 16'h0000;
        for (int i = 15; i >= 0; i--) if (m[i]) a = 16'((i < 2 ? i + 1 : i) * 2);
        return a;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("mismatch at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict;
        if (fails == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic drain;
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 80) begin
            @(negedge sys_clk);
            k++;
        end
        if (exp_q.size() != 0) begin
            fails++;
            $display("mismatch at %0t: vector never loaded", $time);
            exp_q.delete();
        end
    endtask

    task automatic serve(input logic [15:0] m);
        src = m;
        exp_q.push_back(exp_addr(m));
        drain();
        src = 16'h0000;
        repeat (4) @(negedge sys_clk);
    endtask

    // ============================================================
    // watcher: each vector load takes the oldest expectation
    always @(negedge sys_clk) begin
        if (pc_load === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("mismatch at %0t: load with nothing accepted", $time);
            end else begin
                e = exp_q.pop_front();
                check(vec_addr, e);
                check({11'h000, vec_num}, {1'b0, e[15:1]} + 16'h0001);
            end
        end
    end

    initial begin
        #20000;
        fails++;
        $display("mismatch at %0t: run hung", $time);
        give_verdict();
    end

    // ============================================================
    // stimulus
    initial begin
        repeat (3) @(negedge sys_clk);
        exp_q.push_back(16'h0000);
        rst_b = 1'b1;
        drain();
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < 16; i++) serve(16'h0001 << i);
        // slow core so the synchronised pins settle before the pick
        delay = 4'h4;
        repeat (24) serve(16'($random(seed)) | 16'h8000);
        delay = 4'h0;
        src = 16'h8000;
        wdog = 1'b1;
        exp_q.push_back(16'h0000);
        exp_q.push_back(16'h001E);
        @(negedge sys_clk);
        wdog = 1'b0;
        check({15'h0000, core_reset}, 16'h0001);
        drain();
        src = 16'h0008;
        pin_b = 1'b0;
        exp_q.push_back(16'h0000);
        exp_q.push_back(16'h0006);
        repeat (4) @(negedge sys_clk);
        check({14'h0000, core_reset, pending}, 16'h0002);
        pin_b = 1'b1;
        drain();
        src = 16'h0000;
        repeat (4) @(negedge sys_clk);
        rogue = 1'b1;
        @(negedge sys_clk);
        rogue = 1'b0;
        repeat (4) @(negedge sys_clk);
        check(16'(exp_q.size()), 16'h0000);
        give_verdict();
    end
endmodule // tb
